// file: hdl/sxp_device.sv
// Front end: captures parallel words, steers them by pin mode, buffers the result
`timescale 1ns/1ps
`default_nettype none
`include "sxp_params.svh"

module sxp_device (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // Link to the source
  sxp_if.dev               link,
  // Host register port
  input  wire logic [7:0]  host_addr,
  input  wire logic [15:0] host_wdata,
  input  wire logic        host_wr,
  input  wire logic        host_rd,
  output logic [15:0]      host_rdata,
  // Serializer side
  output logic             out_valid,
  input  wire logic        out_ready,
  output logic [19:0]      out_word,
  output logic [1:0]       out_mode,
  output logic             out_wide,
  output logic             out_mute,
  // Processing controls
  output logic [6:0]       proc_enable,
  output logic             h_config,
  output logic [31:0]      video_format
);
  // ----------------------------------------------------------------
  // 8b/10b tables, negative running disparity columns
  // ----------------------------------------------------------------
  localparam logic [5:0] T6 [32] = '{
    6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
    6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
  localparam logic [3:0] T4 [8]  = '{4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};
  localparam logic [3:0] K4 [8]  = '{4'h4, 4'h9, 4'h5, 4'h3, 4'h2, 4'ha, 4'h6, 4'h8};
  localparam logic [5:0] K28_6B  = 6'h0f;
  localparam logic [4:0] K28_X   = 5'd28;

  function automatic logic [2:0] ones(input logic [5:0] v);
    logic [2:0] n;
    n = '0;
    for (int i = 0; i < 6; i++) begin
      n = n + {2'b00, v[i]};
    end
    return n;
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [15:0]        proc_dis_r;
  logic [15:0]        edh_flags_r;
  logic [15:0]        fmt_a_r;
  logic [15:0]        fmt_b_r;
  logic [15:0]        rdata_r;
  logic               rd_r;
  logic               mute_r;
  sxp_pkg::sxp_mode_t mode_r;
  logic [15:0]        status;
  logic [3:0]         level;

  // ----------------------------------------------------------------
  // Capture path
  // ----------------------------------------------------------------
  sxp_pkg::sxp_mode_t mode;
  logic               wide;
  logic               take;
  logic               in_ready;
  logic [22:0]        in_data;
  logic [22:0]        fifo_data;
  logic               sync_insert_request;
  logic               special_char_flag;
  logic [7:0]         tbyte;
  logic [7:0]         code_byte;
  logic               code_special;
  logic [9:0]         code10;
  logic               rd_nxt;
  logic [19:0]        word;

  // Pins decoded on every word, so a change lands on the next capture
  assign mode = sxp_pkg::sxp_decode_mode(link.video_processing_select, link.transport_mode_select,
                                         link.rate_select);
  // Transport mode overrides the width pin
  assign wide = link.bus_width_select && (mode != sxp_pkg::SXP_MODE_TRANSPORT);

  // Transport control bits are never data
  assign sync_insert_request = link.din[19];
  assign special_char_flag   = link.din[18];
  assign tbyte               = link.din[17:10];

  // Padding inserted ahead of the coder
  assign code_byte    = sync_insert_request ? `SXP_SYNC_CHAR : tbyte;
  assign code_special = sync_insert_request || special_char_flag;

  always_comb begin
    logic [4:0] x;
    logic [2:0] y;
    logic       k28;
    logic       alt;
    logic       rd_mid;
    logic [5:0] s6;
    logic [5:0] c6;
    logic [3:0] s4;
    logic [3:0] c4;
    s4     = 4'h0;
    c4     = 4'h0;
    x      = code_byte[4:0];
    y      = code_byte[7:5];
    k28    = code_special && (x == K28_X);
    s6     = k28 ? K28_6B : T6[x];
    c6     = (rd_r && (ones(s6) != 3'd3 || (x == 5'd7 && !k28))) ? ~s6 : s6;
    rd_mid = (ones(c6) != 3'd3) ? !rd_r : rd_r;
    alt    = (y == 3'd7) && (code_special ||
             (!rd_mid && (x == 5'd17 || x == 5'd18 || x == 5'd20)) ||
             (rd_mid && (x == 5'd11 || x == 5'd13 || x == 5'd14)));
    if (k28) begin
      c4 = rd_r ? ~K4[y] : K4[y];
    end else begin
      s4 = alt ? 4'h7 : T4[y];
      c4 = (rd_mid && (ones({2'b00, s4}) != 3'd2 || y == 3'd3)) ? ~s4 : s4;
    end
    if (k28) begin
      s4 = 4'h0;
    end
    rd_nxt = (ones({2'b00, c4}) != 3'd2) ? !rd_mid : rd_mid;
    code10 = {c6, c4};
  end

  always_comb begin
    case (mode)
      sxp_pkg::SXP_MODE_TRANSPORT: begin
        word = {10'h000, code10};
      end
      sxp_pkg::SXP_MODE_VIDEO, sxp_pkg::SXP_MODE_THROUGH: begin
        // Lower half read only in 20-bit operation
        word = wide ? link.din : {link.din[19:10], 10'h000};
      end
      default: begin
        word = '0;
      end
    endcase
  end

  // Transport mode captures on every unmuted edge with buffer room, padding covers idle source cycles
  assign take    = !mute_r && (mode != sxp_pkg::SXP_MODE_INVALID) &&
                   (link.din_valid || mode == sxp_pkg::SXP_MODE_TRANSPORT);
  assign in_data = {mode, wide, word};
  assign link.accept = in_ready;

  // Sampled into the buffer on the rising edge
  sxp_fifo #(
    .WIDTH (`SXP_FIFO_WIDTH),
    .DEPTH (`SXP_FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .nrst      (nrst),
    .in_valid  (take),
    .in_ready  (in_ready),
    .in_data   (in_data),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (fifo_data),
    .level     (level)
  );

  assign out_word = fifo_data[19:0];
  assign out_wide = fifo_data[20];
  assign out_mode = fifo_data[22:21];
  assign out_mute = mute_r;

  // ----------------------------------------------------------------
  // Running disparity and state
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_r <= 1'b0;
    end else if (take && in_ready && mode == sxp_pkg::SXP_MODE_TRANSPORT) begin
      rd_r <= rd_nxt;
    end
  end

  // Mute follows clock presence one cycle late; stalls capture from then on, so one word can still be taken after clock loss
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mute_r <= 1'b1;
    end else begin
      mute_r <= !link.pclk_running;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode_r <= sxp_pkg::SXP_MODE_INVALID;
    end else begin
      mode_r <= mode;
    end
  end

  // ----------------------------------------------------------------
  // Host registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      proc_dis_r <= `SXP_PROC_DIS_RST;
    end else if (host_wr && host_addr == `SXP_REG_PROC_DIS) begin
      proc_dis_r <= host_wdata & `SXP_PROC_DIS_MASK;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      edh_flags_r <= `SXP_EDH_RST;
    end else if (host_wr && host_addr == `SXP_REG_EDH_FLAGS) begin
      edh_flags_r <= {1'b0, host_wdata[14:0]};
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fmt_a_r <= `SXP_FMT_RST;
      fmt_b_r <= `SXP_FMT_RST;
    end else if (host_wr) begin
      if (host_addr == `SXP_REG_FMT_A) begin
        fmt_a_r <= host_wdata;
      end
      if (host_addr == `SXP_REG_FMT_B) begin
        fmt_b_r <= host_wdata;
      end
    end
  end

  assign status = {9'h000, level, mute_r, mode_r};

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= '0;
    end else if (host_rd) begin
      case (host_addr)
        `SXP_REG_PROC_DIS:  rdata_r <= proc_dis_r;
        `SXP_REG_EDH_FLAGS: rdata_r <= edh_flags_r;
        `SXP_REG_STATUS:    rdata_r <= status;
        `SXP_REG_FMT_A:     rdata_r <= fmt_a_r;
        `SXP_REG_FMT_B:     rdata_r <= fmt_b_r;
        default:            rdata_r <= '0;
      endcase
    end else begin
      rdata_r <= '0;
    end
  end

  assign host_rdata = rdata_r;

  // Processing only in video mode, each function off by its own bit
  assign proc_enable  = (mode_r == sxp_pkg::SXP_MODE_VIDEO) ? ~proc_dis_r[6:0] : 7'h00;
  assign h_config     = proc_dis_r[`SXP_BIT_H_CONFIG];
  assign video_format = {fmt_b_r, fmt_a_r};
endmodule // sxp_device

`default_nettype wire

// file: include/sxp_params.svh
// Constants of the parallel input front end: register map, fields, resets, codes
//
// Functional notes
// - Words sampled on rising parallel clock edge
// - Operating mode chosen only by pin levels
// - Video mode takes 10/20-bit words, processing on
// - Transport mode: upper bytes, 8b/10b coded, padded
// - Data-through forwards words unchanged, no coding
// - Processing functions on at reset, disable bits
// - Width pin sets input bus width
// - 20-bit video: luma upper, chroma lower
// - 10-bit video: upper only, lower undriven
// - Transport mode forces 10-bit, lower undriven
// - Transport byte on bits 17..10, msb 17
// - Bit 19 sync request, bit 18 special flag
// - Data-through width follows width pin
// - Mode decoded from three pin levels
// - Source clocks at the format's rate
// - Output muted on parallel clock loss
// - Sync insert on request, coded afterwards
// - Special flag high for control characters
`ifndef SXP_PARAMS_SVH
`define SXP_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SXP_REG_PROC_DIS   8'h00
`define SXP_REG_EDH_FLAGS  8'h02
`define SXP_REG_STATUS     8'h03
`define SXP_REG_FMT_A      8'h0a
`define SXP_REG_FMT_B      8'h0b

// ----------------------------------------------------------------
// Processing disable fields
// ----------------------------------------------------------------
`define SXP_BIT_TIMING_REF   0
`define SXP_BIT_LINE_NUMBER  1
`define SXP_BIT_LINE_CHECK   2
`define SXP_BIT_ANC_CHECKSUM 3
`define SXP_BIT_ERROR_PACKET 4
`define SXP_BIT_BAD_CODE     5
`define SXP_BIT_PAYLOAD_ID   6
`define SXP_BIT_H_CONFIG     8
`define SXP_PROC_DIS_MASK    16'h017f

// ----------------------------------------------------------------
// Reset values, codes and buffer sizes
// ----------------------------------------------------------------
`define SXP_PROC_DIS_RST   16'h0000
`define SXP_EDH_RST        16'h0000
`define SXP_FMT_RST        16'h0000
`define SXP_SYNC_CHAR      8'hbc
`define SXP_FIFO_DEPTH     8
`define SXP_FIFO_WIDTH     23

`endif

// file: include/sxp_pkg.sv
// Types and mode decode shared by both ends of the parallel input port
package sxp_pkg;

  typedef enum logic [1:0] {
    SXP_MODE_VIDEO,
    SXP_MODE_TRANSPORT,
    SXP_MODE_THROUGH,
    SXP_MODE_INVALID
  } sxp_mode_t;

  function automatic sxp_mode_t sxp_decode_mode(input logic video_processing_select,
                                                input logic transport_mode_select,
                                                input logic rate_select);
    sxp_mode_t m;
    m = SXP_MODE_INVALID;
    if (video_processing_select && !transport_mode_select) begin
      m = SXP_MODE_VIDEO;
    end else if (!video_processing_select && transport_mode_select && rate_select) begin
      m = SXP_MODE_TRANSPORT;
    end else if (!video_processing_select && !transport_mode_select) begin
      m = SXP_MODE_THROUGH;
    end
    return m;
  endfunction

endpackage

// file: include/sxp_if.sv
// Parallel word bus, mode pins and clock presence between source and front end
`timescale 1ns/1ps
`default_nettype none

interface sxp_if;
  logic [19:0] din;
  logic        din_lo_oe;
  logic        din_valid;
  logic        accept;
  logic        video_processing_select;
  logic        transport_mode_select;
  logic        rate_select;
  logic        bus_width_select;
  logic        pclk_running;

  modport dev (
    input  din, din_lo_oe, din_valid,
    input  video_processing_select, transport_mode_select, rate_select, bus_width_select,
    input  pclk_running,
    output accept
  );

  modport src (
    output din, din_lo_oe, din_valid,
    output video_processing_select, transport_mode_select, rate_select, bus_width_select,
    output pclk_running,
    input  accept
  );
endinterface

`default_nettype wire

// file: hdl/sxp_fifo.sv
// Flop-based word FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module sxp_fifo #(
  parameter int WIDTH = 23,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         nrst,
  // Fill side
  input  wire logic                         in_valid,
  output logic                              in_ready,
  input  wire logic [WIDTH-1:0]             in_data,
  // Drain side
  output logic                              out_valid,
  input  wire logic                         out_ready,
  output logic [WIDTH-1:0]                  out_data,
  // Fill level
  output logic [$clog2(DEPTH+1)-1:0]        level
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0]           mem_r [DEPTH];
  logic [AW-1:0]              wr_r;
  logic [AW-1:0]              rd_r;
  logic [$clog2(DEPTH+1)-1:0] cnt_r;
  logic                       push;
  logic                       pop;

  assign in_ready  = (cnt_r != DEPTH[$clog2(DEPTH+1)-1:0]);
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rd_r];
  assign level     = cnt_r;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      if (push) begin
        wr_r <= bump(wr_r);
      end
      if (pop) begin
        rd_r <= bump(rd_r);
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= '0;
    end else if (push && !pop) begin
      cnt_r <= cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end
endmodule // sxp_fifo

`default_nettype wire

// file: hdl/sxp_source.sv
// Upstream source end: formats user words onto the parallel bus and drives mode pins
`timescale 1ns/1ps
`default_nettype none
`include "sxp_params.svh"

module sxp_source (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // Link to the front end
  sxp_if.src               link,
  // Mode configuration levels
  input  wire logic        cfg_video_processing_select,
  input  wire logic        cfg_transport_mode_select,
  input  wire logic        cfg_rate_select,
  input  wire logic        cfg_bus_width_select,
  input  wire logic        cfg_clock_running,
  // User words
  input  wire logic [19:0] usr_word,
  input  wire logic        usr_special,
  input  wire logic        usr_valid,
  output logic             usr_ready
);
  sxp_pkg::sxp_mode_t mode;
  logic [19:0]        din_r;
  logic [19:0]        din_nxt;
  logic               lo_oe_r;
  logic               lo_oe_nxt;
  logic               valid_r;
  logic               load;

  // Mode exists only as pin levels
  assign link.video_processing_select = cfg_video_processing_select;
  assign link.transport_mode_select   = cfg_transport_mode_select;
  assign link.rate_select             = cfg_rate_select;
  assign link.bus_width_select        = cfg_bus_width_select;
  assign link.pclk_running            = cfg_clock_running;
  assign link.din                     = din_r;
  assign link.din_lo_oe               = lo_oe_r;
  assign link.din_valid               = valid_r;

  assign mode      = sxp_pkg::sxp_decode_mode(cfg_video_processing_select, cfg_transport_mode_select,
                                              cfg_rate_select);
  assign load      = link.accept || !valid_r;
  assign usr_ready = load;

  always_comb begin
    din_nxt   = '0;
    lo_oe_nxt = 1'b0;
    if (mode == sxp_pkg::SXP_MODE_TRANSPORT) begin
      // Empty user queue becomes a padding request
      din_nxt = {!usr_valid, usr_special, usr_word[7:0], 10'h000};
    end else if (cfg_bus_width_select && mode != sxp_pkg::SXP_MODE_INVALID) begin
      // Lower half stays undriven unless a wide mode is really selected
      din_nxt   = usr_word;
      lo_oe_nxt = 1'b1;
    end else begin
      din_nxt = {usr_word[9:0], 10'h000};
    end
  end

  // Word stands until the front end raises accept (buffer room), even if it is muted and drops the word
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      din_r   <= '0;
      lo_oe_r <= 1'b0;
      valid_r <= 1'b0;
    end else if (load) begin
      din_r   <= din_nxt;
      lo_oe_r <= lo_oe_nxt;
      valid_r <= usr_valid;
    end
  end
endmodule // sxp_source

`default_nettype wire

// file: bench/sxp_props.sv
// Checker on the parallel link between source and front end
`timescale 1ns/1ps
`default_nettype none

module sxp_props (
  // Clock and reset
  input wire logic        clk,
  input wire logic        nrst,
  // Link signals
  input wire logic [19:0] din,
  input wire logic        din_lo_oe,
  input wire logic        din_valid,
  input wire logic        accept,
  input wire logic        video_processing_select,
  input wire logic        transport_mode_select,
  input wire logic        rate_select,
  input wire logic        bus_width_select,
  input wire logic        pclk_running
);
  // Pin combinations that select no mode
  logic bad_mode;
  assign bad_mode = (video_processing_select && transport_mode_select) ||
                    (!video_processing_select && transport_mode_select && !rate_select);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_narrow_lo_off: assert property (!bus_width_select && $past(!bus_width_select) |-> !din_lo_oe)
    else $error("lower bus driven in narrow mode");
  a_transport_lo_off: assert property (transport_mode_select && $past(transport_mode_select) |-> !din_lo_oe)
    else $error("lower bus driven in transport mode");
  a_lo_only_wide: assert property (din_lo_oe |-> bus_width_select || $past(bus_width_select))
    else $error("lower bus driven without wide pin");
  a_hold_word: assert property (din_valid && !accept |=> din_valid && $stable(din))
    else $error("word dropped before it was taken");
  a_idle_reset: assert property ($past(!nrst) |-> !din_valid)
    else $error("word present right after reset");
  a_fill_by_take: assert property ($fell(accept) |-> $past(din_valid) || $past(transport_mode_select))
    else $error("buffer filled without a word");
  a_no_take_muted: assert property ($fell(accept) |-> $past(pclk_running, 2))
    else $error("word taken while clock lost");
  a_no_take_bad: assert property ($fell(accept) |-> !($past(bad_mode) && $past(bad_mode, 2)))
    else $error("word taken in invalid mode");
endmodule // sxp_props

`default_nettype wire

// file: bench/tb.sv
// Self-checking bench: source and front end joined over the link
`timescale 1ns/1ps
`default_nettype none
`include "sxp_params.svh"

module tb;
  logic        clk;
  logic        nrst;
  logic        cfg_vid;
  logic        cfg_ts;
  logic        cfg_rate;
  logic        cfg_wide;
  logic        cfg_run;
  logic [19:0] usr_word;
  logic        usr_special;
  logic        usr_valid;
  logic        usr_ready;
  logic [7:0]  host_addr;
  logic [15:0] host_wdata;
  logic [15:0] host_rdata;
  logic        host_wr;
  logic        host_rd;
  logic        out_valid;
  logic        out_ready;
  logic [19:0] out_word;
  logic [1:0]  out_mode;
  logic        out_wide;
  logic        out_mute;
  logic [6:0]  proc_enable;
  logic        h_config;
  logic [31:0] video_format;
  logic [15:0] fa;
  logic [15:0] fb;
  logic        rd_pos;
  logic        stall;
  logic [22:0] exp_q[$];
  int          n_mismatch;
  int          checked;
  int          seed;
  int          cyc;

  sxp_if link();
  sxp_source u_sxp_source (.clk(clk), .nrst(nrst), .link(link), .cfg_video_processing_select(cfg_vid),
    .cfg_transport_mode_select(cfg_ts), .cfg_rate_select(cfg_rate), .cfg_bus_width_select(cfg_wide),
    .cfg_clock_running(cfg_run), .usr_word(usr_word), .usr_special(usr_special), .usr_valid(usr_valid),
    .usr_ready(usr_ready));
  sxp_device u_sxp_device (.clk(clk), .nrst(nrst), .link(link), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_wr(host_wr), .host_rd(host_rd), .host_rdata(host_rdata),
    .out_valid(out_valid), .out_ready(out_ready), .out_word(out_word), .out_mode(out_mode),
    .out_wide(out_wide), .out_mute(out_mute), .proc_enable(proc_enable), .h_config(h_config),
    .video_format(video_format));
  sxp_props u_props (.clk(clk), .nrst(nrst), .din(link.din), .din_lo_oe(link.din_lo_oe),
    .din_valid(link.din_valid), .accept(link.accept), .video_processing_select(link.video_processing_select),
    .transport_mode_select(link.transport_mode_select), .rate_select(link.rate_select),
    .bus_width_select(link.bus_width_select), .pclk_running(link.pclk_running));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Narrow words ride in the low ten user bits and leave on the upper half; mode 0 video, 2 through
  function automatic logic [22:0] expect_out(input logic vid, input logic wide, input logic [19:0] w);
    return {wide, vid ? 2'h0 : 2'h2, wide ? w : {w[9:0], 10'h000}};
  endfunction

  task automatic hwr(input logic [7:0] a, input logic [15:0] d);
    host_addr <= a;
    host_wdata <= d;
    host_wr <= 1'b1;
    @(posedge clk);
    host_wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic hrd(input logic [7:0] a, input logic [15:0] e);
    host_addr <= a;
    host_rd <= 1'b1;
    @(posedge clk);
    host_rd <= 1'b0;
    @(posedge clk);
    chk("rdata", {16'h0000, host_rdata}, {16'h0000, e});
  endtask

  task automatic send(input logic [19:0] w, input logic keep);
    usr_word <= w;
    usr_special <= w[18];
    usr_valid <= 1'b1;
    do @(posedge clk); while (usr_ready !== 1'b1);
    if (keep) begin
      exp_q.push_back(expect_out(cfg_vid, cfg_wide, w));
    end
  endtask

  task automatic set_mode(input logic vid, input logic ts, input logic rate, input logic wide);
    cfg_vid <= vid;
    cfg_ts <= ts;
    cfg_rate <= rate;
    cfg_wide <= wide;
    repeat (3) @(posedge clk);
  endtask

  task automatic drain;
    usr_valid <= 1'b0;
    for (int i = 0; i < 400 && (exp_q.size() != 0 || out_valid !== 1'b0); i++) @(posedge clk);
    chk("left", exp_q.size(), 0);
  endtask

  // ----------------------------------------------------------------
  // Clock, sink and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    out_ready <= !stall && ($random(seed) % 4 != 0);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test;
    end
    if (nrst && out_valid === 1'b1 && out_ready === 1'b1) begin
      if (out_mode === 2'h1) begin
        // Every transport word is a K28.5 sync character, sent or padding, so disparity flips each time
        chk("sync", {12'h000, out_wide, out_word}, rd_pos ? 32'h305 : 32'h0fa);
        rd_pos = !rd_pos;
      end else if (exp_q.size() == 0) begin
        chk("extra", {12'h000, out_word}, 32'h0);
      end else begin
        chk("word", {9'h000, out_wide, out_mode, out_word}, {9'h000, exp_q.pop_front()});
      end
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 54;
    {nrst, usr_valid, host_wr, host_rd, stall, rd_pos, cyc, n_mismatch, checked} = '0;
    {cfg_vid, cfg_ts, cfg_rate, cfg_wide, cfg_run} = 5'b10111;
    {usr_word, usr_special, host_addr, host_wdata, out_ready} = '0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    hrd(`SXP_REG_PROC_DIS, 16'h0000);
    chk("proc_en", proc_enable, 32'h7f);
    hwr(`SXP_REG_PROC_DIS, 16'hffff);
    hrd(`SXP_REG_PROC_DIS, 16'h017f);
    chk("proc_off", {h_config, proc_enable}, 32'h80);
    hwr(`SXP_REG_PROC_DIS, 16'h0000);
    fa = $random(seed);
    fb = $random(seed);
    hwr(`SXP_REG_FMT_A, fa);
    hwr(`SXP_REG_FMT_B, fb);
    chk("fmt", video_format, {fb, fa});
    hrd(`SXP_REG_FMT_B, fb);
    hwr(`SXP_REG_EDH_FLAGS, 16'hffff);
    hrd(`SXP_REG_EDH_FLAGS, 16'h7fff);
    hrd(8'h05, 16'h0000);
    // Video and data-through, both widths, corner words first
    for (int m = 0; m < 4; m++) begin
      set_mode(m[1], 1'b0, m[0], m[0]);
      send(20'hfffff, 1'b1);
      send(20'h00000, 1'b1);
      repeat (12) send($random(seed), 1'b1);
      drain;
    end
    // Fill the buffer, hold a ninth word on the bus
    set_mode(1'b1, 1'b0, 1'b1, 1'b1);
    stall <= 1'b1;
    repeat (9) send($random(seed), 1'b1);
    usr_valid <= 1'b0;
    repeat (3) @(posedge clk);
    chk("full", link.accept, 0);
    hrd(`SXP_REG_STATUS, 16'h0040);
    stall <= 1'b0;
    drain;
    // Invalid pin combinations drop the bus
    for (int m = 0; m < 2; m++) begin
      set_mode(m[0], 1'b1, m[0], 1'b1);
      repeat (4) send($random(seed), 1'b0);
      usr_valid <= 1'b0;
      repeat (10) @(posedge clk);
      chk("bad_out", out_valid, 0);
    end
    // Clock loss mutes and drops words
    set_mode(1'b1, 1'b0, 1'b1, 1'b1);
    cfg_run <= 1'b0;
    repeat (3) @(posedge clk);
    chk("mute", out_mute, 1);
    repeat (4) send($random(seed), 1'b0);
    usr_valid <= 1'b0;
    repeat (6) @(posedge clk);
    chk("mute_out", out_valid, 0);
    // Idle bus carries a sync request, so the word caught at the mode switch is padding
    usr_word <= 20'h80000;
    cfg_run <= 1'b1;
    repeat (3) @(posedge clk);
    chk("unmute", out_mute, 0);
    // Transport with the wide pin set: special-flagged sync bytes and padding only
    set_mode(1'b0, 1'b1, 1'b1, 1'b1);
    chk("ts_proc", proc_enable, 0);
    repeat (6) send({2'b01, 10'h000, 8'hbc}, 1'b0);
    usr_valid <= 1'b0;
    repeat (40) @(posedge clk);
    set_mode(1'b0, 1'b0, 1'b1, 1'b0);
    drain;
    stop_test;
  end
endmodule // tb

`default_nettype wire
